// ---- ppp_consts.vh ----
// Purpose: Constants for the programmable parallel port
// Assumes: Included by every design file of the block
// Notes: Offsets are byte addresses on the plain register port
`ifndef PPP_CONSTS_VH
`define PPP_CONSTS_VH

// Register offsets
`define PPP_OFS_PA 2'H0
`define PPP_OFS_PB 2'H1
`define PPP_OFS_PC 2'H2
`define PPP_OFS_CW 2'H3

// Control word fields
`define PPP_CW_SEL 7
`define PPP_CW_A_M2 6
`define PPP_CW_A_M1 5
`define PPP_CW_PA_IN 4
`define PPP_CW_PCU_IN 3
`define PPP_CW_B_M1 2
`define PPP_CW_PB_IN 1
`define PPP_CW_PCL_IN 0
`define PPP_CW_RST 8'H9B

// Bit set/reset fields
`define PPP_BSR_HI 3
`define PPP_BSR_LO 1
`define PPP_BSR_VAL 0

// Third-port line roles
`define PPP_PC_INT_REQUEST_B 0
`define PPP_PC_HS_B 1
`define PPP_PC_STB_B 2
`define PPP_PC_INT_REQUEST_A 3
`define PPP_PC_STB_A 4
`define PPP_PC_IBF_A 5
`define PPP_PC_ACK_A 6
`define PPP_PC_OBF_A 7

// Bit set/reset codes of the enable flags
`define PPP_BSR_INT_ENABLE_FLAG_AI 3'H4
`define PPP_BSR_INT_ENABLE_FLAG_AO 3'H6
`define PPP_BSR_INT_ENABLE_FLAG_B 3'H2

// Common values
`define PPP_ONES 8'HFF
`define PPP_ZERO 8'H00
`define PPP_NIB_ONES 4'HF
`define PPP_NIB_ZERO 4'H0
`define PPP_IDLE 1'B1

`endif

// ---- ppp_sync.v ----
// Purpose: Two-stage synchroniser with edge detect
// Assumes: Input idles high
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`include "ppp_consts.vh"

module ppp_sync
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Raw input
   input wire din,
   // Synchronised level and edges
   output reg level,
   output wire rise,
   output wire fall
);

reg meta;
reg level_d;

always @(posedge core_clk)
begin
   if (sys_rst)
   begin
      meta <= `PPP_IDLE;
      level <= `PPP_IDLE;
      level_d <= `PPP_IDLE;
   end
   else
   begin
      meta <= din;
      level <= meta;
      level_d <= level;
   end
end

assign rise = level & ~level_d;
assign fall = ~level & level_d;

endmodule // ppp_sync

// ---- ppp_port.v ----
// Purpose: Three-port parallel interface with handshakes
// Assumes: Host strobes are one cycle and synchronous
// Notes: Reads return data in the cycle after the strobe
//
// Summary of operation
// RQ1: Basic mode: four sections, one means input
// RQ2: Strobed mode forms two port groups
// RQ3: Strobed data ports latch either direction
// RQ4: Load strobe low loads the input latch
// RQ5: Buffer-full set by strobe, cleared after read
// RQ6: Input request set after strobe, read clears
// RQ7: Input enables on third-port bits 4 and 2
// RQ8: Write drives output-full low, accept clears
// RQ9: Peripheral pulls accept low after taking data
// RQ10: Output request set when accepted, write clears
// RQ11: Output enables on third-port bits 6 and 2
// RQ12: Bidirectional mode uses first port, five lines
// RQ13: Bidirectional mode latches both directions
// RQ14: First port driven only while accept low
// RQ15: Bidirectional flags follow write and strobe
// RQ16: Bidirectional enables on bits 6 and 4
// RQ17: One request serves both bidirectional sides
// RQ18: Mode write clears outputs and status flags
// RQ19: Mode write and reset clear all enables
// RQ20: Reset makes all lines inputs, held high
// RQ21: Bit set enables, bit reset disables
// RQ22: Strobes synchronised and edge detected first; the port uses the synchronised levels, and rise and fall are left unconnected
`timescale 1ns/100ps
`include "ppp_consts.vh"

module ppp_port
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Register port
   input wire [1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // First port
   input wire [7:0] pa_in,
   output reg [7:0] pa_out,
   output reg [7:0] pa_oe,
   // Second port
   input wire [7:0] pb_in,
   output reg [7:0] pb_out,
   output reg [7:0] pb_oe,
   // Third port
   input wire [7:0] pc_in,
   output reg [7:0] pc_out,
   output reg [7:0] pc_oe
);

////////////////////////////////////////////////////////////////
// Control state

reg [7:0] cw;
reg [7:0] out_a;
reg [7:0] out_b;
reg [7:0] in_a;
reg [7:0] in_b;
reg [7:0] pc_latch;
reg input_side_int_enable;
reg output_side_int_enable;
reg int_enable_flag_b;
reg input_buffer_full_a;
reg input_buffer_full_b;
reg output_buffer_full_n_a;
reg output_buffer_full_n_b;
reg int_request_ai;
reg int_request_ao;
reg int_request_b;
reg rd_a_d;
reg rd_b_d;
reg wr_a_d;
reg wr_b_d;

wire load_strobe_n_a;
wire accept_n_a;
wire hs_n_b;

////////////////////////////////////////////////////////////////
// Strobe synchronisers

ppp_sync u_stb_a
(
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .din(pc_in[`PPP_PC_STB_A]),
   .level(load_strobe_n_a),
   .rise(),
   .fall()
); // RQ22

ppp_sync u_ack_a
(
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .din(pc_in[`PPP_PC_ACK_A]),
   .level(accept_n_a),
   .rise(),
   .fall()
); // RQ22

ppp_sync u_hs_b
(
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .din(pc_in[`PPP_PC_STB_B]),
   .level(hs_n_b),
   .rise(),
   .fall()
); // RQ22

////////////////////////////////////////////////////////////////
// Mode decode

wire a_m2 = cw[`PPP_CW_A_M2]; // RQ12
wire a_m1 = ~a_m2 & cw[`PPP_CW_A_M1]; // RQ2
wire b_m1 = cw[`PPP_CW_B_M1]; // RQ2
wire a_in = cw[`PPP_CW_PA_IN];
wire b_in = cw[`PPP_CW_PB_IN];
wire a_rx = (a_m1 & a_in) | a_m2;
wire a_tx = (a_m1 & ~a_in) | a_m2;
wire b_rx = b_m1 & b_in;
wire b_tx = b_m1 & ~b_in;

wire wr_cw = reg_wr & (reg_addr == `PPP_OFS_CW);
wire mode_set = wr_cw & reg_wdata[`PPP_CW_SEL];
wire bsr = wr_cw & ~reg_wdata[`PPP_CW_SEL];
wire [2:0] bsr_bit = reg_wdata[`PPP_BSR_HI:`PPP_BSR_LO];
wire bsr_val = reg_wdata[`PPP_BSR_VAL];
wire rd_a = reg_rd & (reg_addr == `PPP_OFS_PA);
wire rd_b = reg_rd & (reg_addr == `PPP_OFS_PB);
wire wr_a = reg_wr & (reg_addr == `PPP_OFS_PA);
wire wr_b = reg_wr & (reg_addr == `PPP_OFS_PB);
wire wr_c = reg_wr & (reg_addr == `PPP_OFS_PC);

////////////////////////////////////////////////////////////////
// Mode word, enables and output latches

always @(posedge core_clk)
begin
   if (sys_rst)
   begin
      cw <= `PPP_CW_RST; // RQ20
      out_a <= `PPP_ZERO;
      out_b <= `PPP_ZERO;
      pc_latch <= `PPP_ZERO;
      input_side_int_enable <= 1'B0; // RQ19
      output_side_int_enable <= 1'B0; // RQ19
      int_enable_flag_b <= 1'B0; // RQ19
   end
   else if (mode_set)
   begin
      cw <= reg_wdata;
      out_a <= `PPP_ZERO; // RQ18
      out_b <= `PPP_ZERO; // RQ18
      pc_latch <= `PPP_ZERO; // RQ18
      input_side_int_enable <= 1'B0; // RQ19
      output_side_int_enable <= 1'B0; // RQ19
      int_enable_flag_b <= 1'B0; // RQ19
   end
   else
   begin
      if (wr_a)
      begin
         out_a <= reg_wdata; // RQ3 RQ13
      end
      if (wr_b)
      begin
         out_b <= reg_wdata; // RQ3
      end
      if (wr_c)
      begin
         pc_latch <= reg_wdata;
      end
      if (bsr)
      begin
         pc_latch[bsr_bit] <= bsr_val;
         // Enable flags sit on the strobe and accept positions
         if (bsr_bit == `PPP_BSR_INT_ENABLE_FLAG_AI)
         begin
            input_side_int_enable <= bsr_val; // RQ7 RQ16 RQ21
         end
         if (bsr_bit == `PPP_BSR_INT_ENABLE_FLAG_AO)
         begin
            output_side_int_enable <= bsr_val; // RQ11 RQ16 RQ21
         end
         if (bsr_bit == `PPP_BSR_INT_ENABLE_FLAG_B)
         begin
            int_enable_flag_b <= bsr_val; // RQ7 RQ11 RQ21
         end
      end
   end
end

////////////////////////////////////////////////////////////////
// Strobe edges of the host bus

always @(posedge core_clk)
begin
   if (sys_rst)
   begin
      rd_a_d <= 1'B0;
      rd_b_d <= 1'B0;
      wr_a_d <= 1'B0;
      wr_b_d <= 1'B0;
   end
   else
   begin
      // Cycle after the strobe stands for its rising edge
      rd_a_d <= rd_a; // RQ22
      rd_b_d <= rd_b; // RQ22
      wr_a_d <= wr_a; // RQ22
      wr_b_d <= wr_b; // RQ22
   end
end

////////////////////////////////////////////////////////////////
// Group A handshake

always @(posedge core_clk)
begin
   if (sys_rst || mode_set)
   begin
      in_a <= `PPP_ZERO;
      input_buffer_full_a <= 1'B0; // RQ18
      output_buffer_full_n_a <= 1'B1; // RQ18
      int_request_ai <= 1'B0; // RQ18
      int_request_ao <= 1'B0; // RQ18
   end
   else
   begin
      if (a_rx && !load_strobe_n_a)
      begin
         in_a <= pa_in; // RQ4 RQ13
      end
      // Strobe wins over a read clearing the flag
      if (a_rx && !load_strobe_n_a)
      begin
         input_buffer_full_a <= 1'B1; // RQ5 RQ15
      end
      else if (rd_a_d)
      begin
         input_buffer_full_a <= 1'B0; // RQ5
      end
      if (rd_a)
      begin
         int_request_ai <= 1'B0; // RQ6
      end
      else if (a_rx && load_strobe_n_a && input_buffer_full_a &&
         input_side_int_enable && !rd_a_d)
      begin
         int_request_ai <= 1'B1; // RQ6
      end
      // Write wins over an accept in the same cycle
      if (a_tx && wr_a_d)
      begin
         output_buffer_full_n_a <= 1'B0; // RQ8 RQ15
      end
      else if (a_tx && !accept_n_a)
      begin
         output_buffer_full_n_a <= 1'B1; // RQ8 RQ9
      end
      if (wr_a)
      begin
         int_request_ao <= 1'B0; // RQ10
      end
      else if (a_tx && accept_n_a && output_buffer_full_n_a &&
         output_side_int_enable && !wr_a_d)
      begin
         int_request_ao <= 1'B1; // RQ10
      end
   end
end

////////////////////////////////////////////////////////////////
// Group B handshake

always @(posedge core_clk)
begin
   if (sys_rst || mode_set)
   begin
      in_b <= `PPP_ZERO;
      input_buffer_full_b <= 1'B0; // RQ18
      output_buffer_full_n_b <= 1'B1; // RQ18
      int_request_b <= 1'B0; // RQ18
   end
   else
   begin
      if (b_rx && !hs_n_b)
      begin
         in_b <= pb_in; // RQ4
         input_buffer_full_b <= 1'B1; // RQ5
      end
      else if (rd_b_d)
      begin
         input_buffer_full_b <= 1'B0; // RQ5
      end
      if (b_tx && wr_b_d)
      begin
         output_buffer_full_n_b <= 1'B0; // RQ8
      end
      else if (b_tx && !hs_n_b)
      begin
         output_buffer_full_n_b <= 1'B1; // RQ8 RQ9
      end
      if ((b_rx && rd_b) || (b_tx && wr_b))
      begin
         int_request_b <= 1'B0; // RQ6 RQ10
      end
      else if (b_rx && hs_n_b && input_buffer_full_b &&
         int_enable_flag_b && !rd_b_d)
      begin
         int_request_b <= 1'B1; // RQ6
      end
      else if (b_tx && hs_n_b && output_buffer_full_n_b &&
         int_enable_flag_b && !wr_b_d)
      begin
         int_request_b <= 1'B1; // RQ10
      end
   end
end

////////////////////////////////////////////////////////////////
// Pin drive

reg [7:0] next_pa_oe;
reg [7:0] next_pb_oe;
reg [7:0] next_pc_out;
reg [7:0] next_pc_oe;

always @*
begin
   next_pa_oe = a_in ? `PPP_ZERO : `PPP_ONES; // RQ1 RQ3
   if (a_m2)
   begin
      next_pa_oe = accept_n_a ? `PPP_ZERO : `PPP_ONES; // RQ14
   end
   next_pb_oe = b_in ? `PPP_ZERO : `PPP_ONES; // RQ1 RQ3
   next_pc_out = pc_latch;
   next_pc_oe[7:4] = cw[`PPP_CW_PCU_IN] ?
      `PPP_NIB_ZERO : `PPP_NIB_ONES; // RQ1
   next_pc_oe[3:0] = cw[`PPP_CW_PCL_IN] ?
      `PPP_NIB_ZERO : `PPP_NIB_ONES; // RQ1
   if (b_m1)
   begin
      next_pc_out[`PPP_PC_INT_REQUEST_B] = int_request_b; // RQ2
      next_pc_out[`PPP_PC_HS_B] = b_in ?
         input_buffer_full_b : output_buffer_full_n_b;
      next_pc_oe[`PPP_PC_INT_REQUEST_B] = 1'B1;
      next_pc_oe[`PPP_PC_HS_B] = 1'B1;
      next_pc_oe[`PPP_PC_STB_B] = 1'B0;
   end
   if (a_rx)
   begin
      next_pc_out[`PPP_PC_IBF_A] = input_buffer_full_a; // RQ5
      next_pc_oe[`PPP_PC_IBF_A] = 1'B1;
      next_pc_oe[`PPP_PC_STB_A] = 1'B0;
   end
   if (a_tx)
   begin
      next_pc_out[`PPP_PC_OBF_A] = output_buffer_full_n_a; // RQ8
      next_pc_oe[`PPP_PC_OBF_A] = 1'B1;
      next_pc_oe[`PPP_PC_ACK_A] = 1'B0;
   end
   if (a_rx || a_tx)
   begin
      // One shared request line for group A
      next_pc_out[`PPP_PC_INT_REQUEST_A] = int_request_ai |
         int_request_ao; // RQ17
      next_pc_oe[`PPP_PC_INT_REQUEST_A] = 1'B1; // RQ12
   end
end

always @(posedge core_clk)
begin
   if (sys_rst)
   begin
      pa_out <= `PPP_ONES; // RQ20
      pa_oe <= `PPP_ZERO; // RQ20
      pb_out <= `PPP_ONES; // RQ20
      pb_oe <= `PPP_ZERO; // RQ20
      pc_out <= `PPP_ONES; // RQ20
      pc_oe <= `PPP_ZERO; // RQ20
   end
   else
   begin
      pa_out <= out_a;
      pa_oe <= next_pa_oe;
      pb_out <= out_b;
      pb_oe <= next_pb_oe;
      pc_out <= next_pc_out;
      pc_oe <= next_pc_oe;
   end
end

////////////////////////////////////////////////////////////////
// Register read

reg [7:0] pc_view;
reg [7:0] next_rdata;

always @*
begin
   pc_view = (pc_in & ~pc_oe) | (pc_out & pc_oe);
   // Flags replace the strobe and accept lines
   if (a_rx)
   begin
      pc_view[`PPP_PC_STB_A] = input_side_int_enable;
   end
   if (a_tx)
   begin
      pc_view[`PPP_PC_ACK_A] = output_side_int_enable;
   end
   if (b_m1)
   begin
      pc_view[`PPP_PC_STB_B] = int_enable_flag_b;
   end
   next_rdata = `PPP_ZERO;
   if (reg_addr == `PPP_OFS_PA)
   begin
      if (a_rx)
      begin
         next_rdata = in_a; // RQ13
      end
      else if (a_in)
      begin
         next_rdata = pa_in; // RQ1
      end
      else
      begin
         next_rdata = out_a;
      end
   end
   else if (reg_addr == `PPP_OFS_PB)
   begin
      if (b_rx)
      begin
         next_rdata = in_b; // RQ3
      end
      else if (b_in)
      begin
         next_rdata = pb_in; // RQ1
      end
      else
      begin
         next_rdata = out_b;
      end
   end
   else if (reg_addr == `PPP_OFS_PC)
   begin
      next_rdata = pc_view;
   end
end

always @(posedge core_clk)
begin
   if (sys_rst)
   begin
      reg_rdata <= `PPP_ZERO;
   end
   else if (reg_rd)
   begin
      reg_rdata <= next_rdata;
   end
   else
   begin
      reg_rdata <= `PPP_ZERO;
   end
end

endmodule // ppp_port

// ---- ppp_port_asserts.sv ----
// Purpose: Concurrent checks on the parallel port pins
// Assumes: One clock, reset synchronous and active high
// Notes: Mode word and input enable are shadowed from writes
`timescale 1ns/100ps
`include "ppp_consts.vh"

module ppp_port_asserts
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Register port
   input wire [1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // First and second port
   input wire [7:0] pa_in,
   input wire [7:0] pa_out,
   input wire [7:0] pa_oe,
   input wire [7:0] pb_in,
   input wire [7:0] pb_out,
   input wire [7:0] pb_oe,
   // Third port
   input wire [7:0] pc_in,
   input wire [7:0] pc_out,
   input wire [7:0] pc_oe
);
   reg [7:0] cw_q;
   reg int_enable_flag_ai;
   wire cw_sel = reg_wr && reg_addr == `PPP_OFS_CW;
   wire cw_wr = cw_sel && reg_wdata[7];
   wire wr_a = reg_wr && reg_addr == `PPP_OFS_PA;
   wire rd_a = reg_rd && reg_addr == `PPP_OFS_PA;
   wire a_in1 = cw_q[6:5] == 2'H1 && cw_q[4];
   wire a_out1 = cw_q[6:5] == 2'H1 && !cw_q[4];
   wire a_bi = cw_q[6];

   ////////////////////////////////////////
   always @(posedge core_clk)
   begin
      if (sys_rst || cw_wr)
         int_enable_flag_ai <= 1'B0;
      else if (cw_sel && reg_wdata[7:1] == 7'H04)
         int_enable_flag_ai <= reg_wdata[0];
      if (sys_rst)
         cw_q <= `PPP_CW_RST;
      else if (cw_wr)
         cw_q <= reg_wdata;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_mode0_set;
      cw_wr && reg_wdata[6:5] == 2'H0 && !reg_wdata[2] ##1 !reg_wr;
   endsequence
   sequence s_stb_low;
      (a_in1 && !pc_in[4] && !reg_wr) [*6];
   endsequence
   sequence s_in_pend;
      (a_in1 && int_enable_flag_ai && pc_in[4] && pc_out[5] && !reg_rd) [*5];
   endsequence
   sequence s_read_idle;
      pc_in[4] [*4] ##0 (rd_a && a_in1) ##1 pc_in[4] [*3];
   endsequence

   AST_MODE0_DIR: assert property (
      s_mode0_set |=> pa_oe == {8{~cw_q[4]}} && pb_oe == {8{~cw_q[1]}}
      && pc_oe == {{4{~cw_q[3]}}, {4{~cw_q[0]}}})
      else $error("mode 0 directions wrong");
   AST_IBF_SET: assert property (s_stb_low |-> pc_out[5])
      else $error("input full not raised");
   AST_IBF_CLR: assert property (s_read_idle |-> !pc_out[5])
      else $error("input full not cleared by read");
   AST_INT_IN_SET: assert property (s_in_pend |-> pc_out[3])
      else $error("input request not raised");
   AST_INT_RD_CLR: assert property (
      rd_a && a_in1 |-> ##[1:3] !pc_out[3])
      else $error("input request not cleared by read");
   AST_OBF_WR: assert property (
      wr_a && a_out1 |-> ##[1:4] !pc_out[7])
      else $error("output full not set by write");
   AST_OBF_ACK: assert property (
      (a_out1 && !pc_in[6] && !reg_wr) [*6] |-> pc_out[7])
      else $error("output full not released by accept");
   AST_INT_WR_CLR: assert property (
      wr_a && a_out1 |-> ##[1:4] !pc_out[3])
      else $error("output request not cleared by write");
   AST_BIDIR_DRV: assert property (
      (a_bi && !pc_in[6]) [*5] |-> pa_oe == 8'HFF)
      else $error("first port not driven during accept");
   AST_BIDIR_HIZ: assert property (
      (a_bi && pc_in[6]) [*5] |-> pa_oe == 8'H00)
      else $error("first port driven without accept");
   AST_MODE_CLR: assert property (
      cw_wr && reg_wdata[6:5] != 2'H0 ##1 !reg_wr |=> !pc_out[3])
      else $error("request survived a mode write");
   AST_RESET: assert property (
      @(posedge core_clk) disable iff (1'B0)
      sys_rst ##1 sys_rst |-> pa_oe == 8'H00 && pb_oe == 8'H00
      && pc_oe == 8'H00 && pa_out == 8'HFF)
      else $error("reset state of pins wrong");
endmodule // ppp_port_asserts

bind ppp_port ppp_port_asserts u_asserts (.core_clk, .sys_rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pa_in,
   .pa_out, .pa_oe, .pb_in, .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe);

// ---- ppp_periph.sv ----
// Purpose: Handshaking peripheral on the port pins
// Assumes: Pin levels resolved from the device enables
// Notes: Released first port lines show inverted last data
`timescale 1ns/100ps

module ppp_periph
(
   // Clock
   input wire core_clk,
   // Device drive
   input wire [7:0] pa_out,
   input wire [7:0] pa_oe,
   input wire [7:0] pb_out,
   input wire [7:0] pb_oe,
   input wire [7:0] pc_out,
   input wire [7:0] pc_oe,
   // Pin levels
   output wire [7:0] pa_in,
   output wire [7:0] pb_in,
   output wire [7:0] pc_in
);
   reg [7:0] drv = 8'H00;
   reg drv_on = 1'B0;
   reg stb_n = 1'B1;
   reg stb_b_n = 1'B1;
   reg acc_n = 1'B1;
   reg auto_acc = 1'B0;
   integer ack_dly = 1;
   reg [7:0] got = 8'H00;
   wire [7:0] far_a = drv_on ? drv : ~drv;
   wire [7:0] far_c = {1'B1, acc_n, 1'B1, stb_n, 1'B1, stb_b_n, 2'H3};

   assign pa_in = (pa_oe & pa_out) | (~pa_oe & far_a);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & 8'HC3);
   assign pc_in = (pc_oe & pc_out) | (~pc_oe & far_c);

   ////////////////////////////////////////
   // Data held past the strobe to cover synchroniser lag
   task load(input [7:0] d);
      begin
         drv <= d;
         drv_on <= 1'B1;
         @(posedge core_clk);
         stb_n <= 1'B0;
         repeat (6) @(posedge core_clk);
         stb_n <= 1'B1;
         repeat (4) @(posedge core_clk);
         drv_on <= 1'B0;
      end
   endtask

   // Take each offered byte after ack_dly cycles
   always @(posedge core_clk)
   begin
      if (auto_acc && pc_oe[7] && pc_out[7] === 1'B0)
      begin
         repeat (ack_dly) @(posedge core_clk);
         acc_n <= 1'B0;
         repeat (6) @(posedge core_clk);
         got <= pa_in;
         acc_n <= 1'B1;
         repeat (4) @(posedge core_clk);
      end
   end
endmodule // ppp_periph

// ---- testbench.sv ----
// Purpose: Self-checking bench for the parallel port
// Assumes: 250 MHz clock, reset held 20 cycles
// Notes: Mode 0 directions from a table, handshakes by hand
`timescale 1ns/100ps
`include "ppp_consts.vh"

module testbench;
   reg core_clk = 1'B0;
   reg sys_rst = 1'B1;
   reg [1:0] reg_addr = 2'H0;
   reg [7:0] reg_wdata = 8'H00;
   reg reg_wr = 1'B0;
   reg reg_rd = 1'B0;
   wire [7:0] reg_rdata, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
   wire [7:0] pc_in, pc_out, pc_oe;
   integer n_mismatch = 0;
   integer n_compared = 0;
   integer cyc = 0;
   integer i;
   reg [7:0] d;
   reg [31:0] rows [0:15];

   ppp_port dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out,
      .pb_oe, .pc_in, .pc_out, .pc_oe);
   ppp_periph periph (.core_clk, .pa_out, .pa_oe, .pb_out, .pb_oe,
      .pc_out, .pc_oe, .pa_in, .pb_in, .pc_in);

   initial forever #2 core_clk = ~core_clk;

   ////////////////////////////////////////
   task summarize;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_mismatch);
         if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   always @(posedge core_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         n_mismatch = n_mismatch + 1;
         summarize;
      end
   end

   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // Pins settled when this returns
   task wr(input [1:0] a, input [7:0] v);
      begin
         reg_addr <= a;
         reg_wdata <= v;
         reg_wr <= 1'B1;
         @(posedge core_clk);
         reg_wr <= 1'B0;
         repeat (2) @(posedge core_clk);
      end
   endtask

   task rd(input [1:0] a);
      begin
         reg_addr <= a;
         reg_rd <= 1'B1;
         @(posedge core_clk);
         reg_rd <= 1'B0;
         @(posedge core_clk);
         d = reg_rdata;
      end
   endtask

   // Wait for the offered byte to be taken
   task wt_obf;
      integer k;
      begin
         k = 0;
         while (pc_out[7] !== 1'B1 && k < 60)
         begin
            @(posedge core_clk);
            k = k + 1;
         end
         repeat (10) @(posedge core_clk);
      end
   endtask

   initial
   begin
      rows = '{32'H80FFFFFF, 32'H81FFFFF0, 32'H82FF00FF, 32'H83FF00F0,
         32'H88FFFF0F, 32'H89FFFF00, 32'H8AFF000F, 32'H8BFF0000,
         32'H9000FFFF, 32'H9100FFF0, 32'H920000FF, 32'H930000F0,
         32'H9800FF0F, 32'H9900FF00, 32'H9A00000F, 32'H9B000000};
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'B0;
      chk(pa_oe | pb_oe | pc_oe, 8'H00);
      chk(pa_out & pc_out, 8'HFF);
      @(posedge core_clk);
      rd(`PPP_OFS_PA);
      chk(d, 8'HFF);
      rd(`PPP_OFS_CW);
      chk(d, 8'H00);
      $display("test reset done");
      for (i = 0; i < 16; i = i + 1)
      begin
         wr(`PPP_OFS_CW, rows[i][31:24]);
         wr(`PPP_OFS_PB, 8'H5A);
         chk(pa_oe, rows[i][23:16]);
         chk(pb_oe, rows[i][15:8]);
         chk(pc_oe, rows[i][7:0]);
         if (rows[i][15:8] === 8'HFF)
            chk(pb_out, 8'H5A);
         rd(`PPP_OFS_PB);
         if (rows[i][15:8] === 8'H00)
            chk(d, 8'HC3);
      end
      $display("test basic mode table done");
      wr(`PPP_OFS_CW, 8'HB6);
      wr(`PPP_OFS_CW, 8'H09);
      wr(`PPP_OFS_CW, 8'H05);
      periph.load(8'H3C);
      repeat (4) @(posedge core_clk);
      chk(pc_out & 8'H28, 8'H28);
      rd(`PPP_OFS_PC);
      chk(d & 8'H14, 8'H14);
      rd(`PPP_OFS_PA);
      chk(d, 8'H3C);
      repeat (3) @(posedge core_clk);
      chk(pc_out & 8'H28, 8'H00);
      wr(`PPP_OFS_CW, 8'H08);
      periph.load(8'HA5);
      repeat (4) @(posedge core_clk);
      chk(pc_out & 8'H28, 8'H20);
      rd(`PPP_OFS_PA);
      chk(d, 8'HA5);
      periph.stb_b_n <= 1'B0;
      repeat (6) @(posedge core_clk);
      periph.stb_b_n <= 1'B1;
      repeat (8) @(posedge core_clk);
      chk(pc_out & 8'H03, 8'H03);
      rd(`PPP_OFS_PB);
      chk(d, 8'HC3);
      repeat (3) @(posedge core_clk);
      chk(pc_out & 8'H03, 8'H00);
      $display("test strobed input done");
      wr(`PPP_OFS_CW, 8'HA0);
      chk(pa_oe, 8'HFF);
      wr(`PPP_OFS_CW, 8'H0D);
      repeat (2) @(posedge core_clk);
      chk(pc_out & 8'H88, 8'H88);
      periph.ack_dly <= 20;
      periph.auto_acc <= 1'B1;
      wr(`PPP_OFS_PA, 8'H5A);
      repeat (10) @(posedge core_clk);
      chk(pc_out & 8'H88, 8'H00);
      wt_obf;
      chk(periph.got, 8'H5A);
      chk(pc_out & 8'H88, 8'H88);
      periph.ack_dly <= 0;
      wr(`PPP_OFS_PA, 8'HC3);
      repeat (4) @(posedge core_clk);
      wt_obf;
      chk(periph.got, 8'HC3);
      $display("test strobed output done");
      periph.ack_dly <= 20;
      wr(`PPP_OFS_CW, 8'HC0);
      chk(pa_oe, 8'H00);
      chk(pc_out & 8'H08, 8'H00);
      wr(`PPP_OFS_CW, 8'H09);
      periph.load(8'H99);
      repeat (4) @(posedge core_clk);
      chk(pc_out & 8'H28, 8'H28);
      rd(`PPP_OFS_PA);
      chk(d, 8'H99);
      repeat (3) @(posedge core_clk);
      chk(pc_out & 8'H28, 8'H00);
      wr(`PPP_OFS_CW, 8'H0D);
      repeat (2) @(posedge core_clk);
      chk(pc_out & 8'H08, 8'H08);
      wr(`PPP_OFS_PA, 8'H77);
      repeat (10) @(posedge core_clk);
      chk(pc_out & 8'H88, 8'H00);
      wt_obf;
      chk(periph.got, 8'H77);
      chk(pc_out & 8'H88, 8'H88);
      wr(`PPP_OFS_CW, 8'HC0);
      chk(pc_out & 8'H88, 8'H80);
      rd(`PPP_OFS_PC);
      chk(d & 8'H50, 8'H00);
      $display("test bidirectional done");
      sys_rst <= 1'B1;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'B0;
      chk(pa_oe | pb_oe | pc_oe, 8'H00);
      chk(pa_out & pc_out, 8'HFF);
      @(posedge core_clk);
      rd(`PPP_OFS_PC);
      chk(d, 8'HFF);
      $display("test second reset done");
      summarize;
   end
endmodule // testbench
